/* include/stc_map.svh */
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define STC_OFS_COUNT_LOW 8'h00
`define STC_OFS_COUNT_HIGH 8'h04
`define STC_OFS_TIMER_CONTROL 8'h08
`define STC_OFS_IRQ_STATUS 8'h0C
`define STC_OFS_IRQ_MASK 8'h10

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define STC_OVF_BIT 0
`define STC_CTRL_RESET 8'h00
`define STC_COUNT_RESET 16'h0000
`define STC_COUNT_MAX 16'hFFFF
`define STC_SEV_TRIGGER_MODE 4'hB

// ---------------------------------------------------------------
// timing counts
// ---------------------------------------------------------------
`define STC_INSTR_DIV_LAST 2'h3

`endif

/* include/stc_pkg.sv */
`default_nettype none

package stc_pkg;

  // timer_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic wide_access_mode;
    logic ccp_timebase_select_high;
    logic [1:0] prescale_select;
    logic ccp_timebase_select_low;
    logic ext_sync_disable;
    logic clock_source_select;
    logic run_enable;
  } stc_ctrl_type;

  // one capture/compare module as seen by this timer
  typedef struct packed {
    logic [3:0] compare_mode_select;
    logic match;
  } stc_ccp_type;

endpackage : stc_pkg

`default_nettype wire

/* hdl/stc_sync2.sv */
`default_nettype none

module stc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,          // bus clock
  input wire logic reset_i,        // async reset, active high
  input wire logic [W-1:0] d_i,    // asynchronous inputs
  output logic [W-1:0] q_o         // synchronised copy
);

  logic [W-1:0] meta_r;

  // first stage feeds the second stage only
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule : stc_sync2

`default_nettype wire

/* hdl/stc_timer.sv */
// How it works
// - clock source select clear: count every instruction cycle, clk/4.
// - clock source select set: count rising edges of pin or aux oscillator.
// - aux oscillator on forces both pins input, ignores direction, reads 0.
// - wide mode: high address is a buffer, low read loads it.
// - wide mode: high write fills buffer, low write loads all 16 bits.
// - wide mode: counter high byte reachable only through the buffer.
// - prescaler cleared by low byte writes only, never by high writes.
// - 16-bit count runs up from 0000 to FFFF then wraps to 0000.
// - wrap sets sticky overflow flag; interrupt only when enabled.
// - compare module in trigger mode on this timer resets count to zero.
// - software write in same cycle as trigger reset wins.
// - trigger reset never sets the overflow flag.
// - two control bits pick this timer or the other per compare module.
`default_nettype none
`include "stc_map.svh"

module stc_timer (
  input wire logic clk_i,                        // bus clock, 40 MHz
  input wire logic reset_i,                      // async reset, high
  input wire logic psel,                         // apb select
  input wire logic penable,                      // apb access phase
  input wire logic pwrite,                       // apb direction
  input wire logic [7:0] paddr,                  // apb byte address
  input wire logic [31:0] pwdata,                // apb write data
  output logic [31:0] prdata,                    // apb read data
  output logic pready,                           // apb ready
  output logic pslverr,                          // apb error
  output logic irq_o,                            // overflow interrupt
  input wire logic aux_oscillator_enable_i,      // from other timer
  input wire logic external_count_input_i,       // count pin
  input wire logic aux_osc_in_pin_i,             // aux oscillator clock
  input wire logic [1:0] port_c_pins_i,          // raw pin levels
  input wire logic [1:0] port_c_direction_i,     // software direction
  input wire stc_pkg::stc_ccp_type ccp_low_i,    // first compare module
  input wire stc_pkg::stc_ccp_type ccp_high_i,   // second compare module
  output logic [1:0] port_dir_o,                 // effective direction
  output logic [1:0] port_read_o,                // pin read value
  output logic [1:0] ccp_uses_this_timer_o,      // per module timebase
  output logic [15:0] count_o                    // live count
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  stc_pkg::stc_ctrl_type ctrl_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0] high_buf_r;
  logic ovf_flag_r;
  logic ovf_mask_r;
  logic [1:0] instr_div_r;
  logic [2:0] presc_r;
  logic [2:0] presc_last;
  logic src_prev_r;
  logic armed_r;
  logic [3:0] sync_q;
  logic ext_s;
  logic aux_s;
  logic [1:0] pins_s;
  logic src_level;
  logic src_tick;
  logic presc_done;
  logic inc;
  logic wrap;
  logic trig_reset;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  stc_sync2 #(
    .W(4)
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({port_c_pins_i, aux_osc_in_pin_i, external_count_input_i}),
    .q_o(sync_q)
  );

  assign ext_s = sync_q[0];
  assign aux_s = sync_q[1];
  assign pins_s = sync_q[3:2];

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup;
  logic access;
  logic wr;
  logic hit_low;
  logic hit_high;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic mapped;

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign hit_low = (paddr == `STC_OFS_COUNT_LOW);
  assign hit_high = (paddr == `STC_OFS_COUNT_HIGH);
  assign hit_ctrl = (paddr == `STC_OFS_TIMER_CONTROL);
  assign hit_stat = (paddr == `STC_OFS_IRQ_STATUS);
  assign hit_mask = (paddr == `STC_OFS_IRQ_MASK);
  assign mapped = hit_low || hit_high || hit_ctrl || hit_stat || hit_mask;

  logic wr_low;
  logic wr_high;
  assign wr_low = wr && hit_low;
  assign wr_high = wr && hit_high;

  // one wait-free answer: data and ready are prepared in setup
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (hit_low)
        prdata[7:0] <= count_r[7:0];
      else if (hit_high)
        // buffer in wide mode, plain byte otherwise
        prdata[7:0] <= ctrl_r.wide_access_mode ?
                       high_buf_r : count_r[15:8];
      else if (hit_ctrl)
        prdata[7:0] <= ctrl_r;
      else if (hit_stat)
        prdata[`STC_OVF_BIT] <= ovf_flag_r;
      else if (hit_mask)
        prdata[`STC_OVF_BIT] <= ovf_mask_r;
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl_r <= `STC_CTRL_RESET;
    else if (wr && hit_ctrl)
      ctrl_r <= pwdata[7:0];
  end

  // ---------------------------------------------------------------
  // high byte buffer
  // ---------------------------------------------------------------
  // loaded in the setup cycle of the low read, same cycle the low
  // byte is sampled, so both halves belong to one count value
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      high_buf_r <= 8'h00;
    else if (ctrl_r.wide_access_mode)
    begin
      if (setup && !pwrite && hit_low)
        high_buf_r <= count_r[15:8];
      else if (wr_high)
        high_buf_r <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // count source selection
  // ---------------------------------------------------------------
  // aux oscillator shares the count pin; when on it is the source
  assign src_level = aux_oscillator_enable_i ? aux_s : ext_s;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      src_prev_r <= 1'b0;
    else
      src_prev_r <= src_level;
  end

  // first rising edge only counts after a falling edge was seen
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      armed_r <= 1'b0;
    else if (!ctrl_r.clock_source_select || !ctrl_r.run_enable)
      armed_r <= 1'b0;
    else if (src_prev_r && !src_level)
      armed_r <= 1'b1;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      instr_div_r <= 2'h0;
    else
      instr_div_r <= instr_div_r + 2'h1;
  end

  // single clock: the unsynchronised option still passes the
  // synchronisers, so trigger reset always works in this design
  always_comb
  begin
    if (!ctrl_r.run_enable)
      src_tick = 1'b0;
    else if (ctrl_r.clock_source_select)
      src_tick = armed_r && !src_prev_r && src_level;
    else
      src_tick = (instr_div_r == `STC_INSTR_DIV_LAST);
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  always_comb
  begin
    case (ctrl_r.prescale_select)
      2'h0: presc_last = 3'h0;
      2'h1: presc_last = 3'h1;
      2'h2: presc_last = 3'h3;
      2'h3: presc_last = 3'h7;
      default: presc_last = 3'h0;
    endcase
  end

  assign presc_done = src_tick && (presc_r == presc_last);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      presc_r <= 3'h0;
    else if (wr_low)
      presc_r <= 3'h0;
    else if (presc_done)
      presc_r <= 3'h0;
    else if (src_tick)
      presc_r <= presc_r + 3'h1;
  end

  // ---------------------------------------------------------------
  // compare module timebase and trigger reset
  // ---------------------------------------------------------------
  logic use_low;
  logic use_high;
  // high bit set: both modules; low bit only: second module only
  assign use_high = ctrl_r.ccp_timebase_select_high ||
                    ctrl_r.ccp_timebase_select_low;
  assign use_low = ctrl_r.ccp_timebase_select_high;

  assign trig_reset =
    (use_low && ccp_low_i.match &&
     ccp_low_i.compare_mode_select == `STC_SEV_TRIGGER_MODE) ||
    (use_high && ccp_high_i.match &&
     ccp_high_i.compare_mode_select == `STC_SEV_TRIGGER_MODE);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ccp_uses_this_timer_o <= 2'h0;
    else
      ccp_uses_this_timer_o <= {use_high, use_low};
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  assign inc = presc_done;
  assign wrap = inc && (count_r == `STC_COUNT_MAX);

  always_comb
  begin
    count_nxt = count_r;
    if (wr_low)
      // write beats trigger and count in the same cycle
      count_nxt = ctrl_r.wide_access_mode ?
                  {high_buf_r, pwdata[7:0]} :
                  {count_r[15:8], pwdata[7:0]};
    else if (wr_high && !ctrl_r.wide_access_mode)
      count_nxt = {pwdata[7:0], count_r[7:0]};
    else if (trig_reset)
      count_nxt = `STC_COUNT_RESET;
    else if (inc)
      count_nxt = count_r + 16'h0001;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      count_r <= `STC_COUNT_RESET;
    else
      count_r <= count_nxt;
  end

  assign count_o = count_r;

  // ---------------------------------------------------------------
  // overflow interrupt
  // ---------------------------------------------------------------
  logic ovf_set;
  // only a natural wrap that is not overridden sets the flag
  assign ovf_set = wrap && !trig_reset && !wr_low &&
                   !(wr_high && !ctrl_r.wide_access_mode);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ovf_flag_r <= 1'b0;
    else if (ovf_set)
      ovf_flag_r <= 1'b1;
    else if (wr && hit_stat && pwdata[`STC_OVF_BIT])
      ovf_flag_r <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      ovf_mask_r <= 1'b0;
    else if (wr && hit_mask)
      ovf_mask_r <= pwdata[`STC_OVF_BIT];
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= ovf_flag_r && ovf_mask_r;
  end

  // ---------------------------------------------------------------
  // oscillator pin override
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      port_dir_o <= 2'h3;
      port_read_o <= 2'h0;
    end
    else if (aux_oscillator_enable_i)
    begin
      port_dir_o <= 2'h3;
      port_read_o <= 2'h0;
    end
    else
    begin
      port_dir_o <= port_c_direction_i;
      port_read_o <= pins_s;
    end
  end

endmodule : stc_timer

`default_nettype wire

/* test/stc_props.sv */
`default_nettype none
`include "stc_map.svh"
module stc_props (
  input wire logic clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic pready, // apb
  input wire logic aux_oscillator_enable_i, // aux on
  input wire logic [1:0] port_c_direction_i, // dir in
  input wire stc_pkg::stc_ccp_type ccp_low_i, // ccp 1
  input wire stc_pkg::stc_ccp_type ccp_high_i, // ccp 2
  input wire logic [1:0] port_dir_o, // dir out
  input wire logic [1:0] port_read_o, // pins out
  input wire logic [1:0] ccp_uses_this_timer_o, // timebase
  input wire logic [15:0] count_o // count
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic wr, ctlw, trig, dis, dis_q, tr_q, chg, inc;
  logic [15:0] cnt_q;
  logic [7:0] gap_q, ctl_q;
  assign wr = psel && penable && pwrite && pready;
  assign ctlw = wr && paddr == 8'h08;
  assign trig = (ccp_low_i.match && ccp_uses_this_timer_o[0] &&
    ccp_low_i.compare_mode_select == `STC_SEV_TRIGGER_MODE) ||
    (ccp_high_i.match && ccp_uses_this_timer_o[1] &&
    ccp_high_i.compare_mode_select == `STC_SEV_TRIGGER_MODE);
  assign dis = wr || trig;
  assign chg = count_o != cnt_q;
  assign inc = count_o == cnt_q + 16'h0001;
  // period is trusted only after a clean increment, writes shift phase
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_q <= 16'h0000;
      gap_q <= 8'h00;
      dis_q <= 1'b0;
      tr_q <= 1'b0;
      ctl_q <= 8'h00;
    end
    else
    begin
      cnt_q <= count_o;
      gap_q <= chg ? 8'h00 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
      dis_q <= dis;
      tr_q <= (dis || dis_q) ? 1'b0 : (chg ? inc : tr_q);
      ctl_q <= ctlw ? pwdata[7:0] : ctl_q;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_top;
    count_o == `STC_COUNT_MAX && !dis;
  endsequence
  sequence s_calm;
    !ctlw ##1 !ctlw;
  endsequence
  chk_aux_pins: assert property (aux_oscillator_enable_i |=>
    port_dir_o == 2'h3 && port_read_o == 2'h0) else $error("aux pins");
  chk_dir_pass: assert property (!aux_oscillator_enable_i |=>
    port_dir_o == $past(port_c_direction_i)) else $error("dir pass");
  chk_trig_reset: assert property (trig && !wr |=>
    count_o == 16'h0000) else $error("trigger reset");
  chk_write_wins: assert property (trig && wr && paddr == 8'h00 |=>
    count_o[7:0] == $past(pwdata[7:0])) else $error("write wins");
  chk_hold_stop: assert property (!ctl_q[0] && !dis |=>
    $stable(count_o)) else $error("stopped count moved");
  chk_tick_period: assert property (chg && inc && tr_q && !dis_q &&
    ctl_q[0] && !ctl_q[1] |-> gap_q == (8'h04 << ctl_q[5:4]) - 8'h01)
    else $error("tick period");
  chk_wrap_zero: assert property (s_top ##1 chg |->
    count_o == 16'h0000) else $error("wrap");
  chk_base_select: assert property (s_calm |->
    ccp_uses_this_timer_o == {ctl_q[6] | ctl_q[3], ctl_q[6]})
    else $error("timebase");
endmodule : stc_props
bind stc_timer stc_props stc_props_inst (
  .clk_i, .reset_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .aux_oscillator_enable_i, .port_c_direction_i, .ccp_low_i, .ccp_high_i,
  .port_dir_o, .port_read_o, .ccp_uses_this_timer_o, .count_o
);
`default_nettype wire

/* test/stc_far_model.sv */
`default_nettype none
module stc_far_model (
  input wire logic clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic fire_i, // send match
  input wire logic which_i, // 0 first, 1 second
  input wire logic [3:0] mode_i, // compare mode
  output var stc_pkg::stc_ccp_type ccp_low_o, // first module
  output var stc_pkg::stc_ccp_type ccp_high_o, // second module
  output logic ext_o, // count pin
  output logic aux_o // aux oscillator
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // compare modules: match is a one-cycle pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ccp_low_o <= '0;
      ccp_high_o <= '0;
    end
    else
    begin
      ccp_low_o <= {mode_i, fire_i && !which_i};
      ccp_high_o <= {mode_i, fire_i && which_i};
    end
  end
  // idle high, so every pulse opens with the falling edge the timer needs
  initial
  begin
    ext_o = 1'b1;
    aux_o = 1'b1;
  end
  task pulse(input int n, input bit sel);
    repeat (n)
    begin
      @(posedge clk_i);
      if (sel)
        aux_o <= 1'b0;
      else
        ext_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      aux_o <= 1'b1;
      ext_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
  endtask : pulse
endmodule : stc_far_model
`default_nettype wire

/* test/stc_timer_tb_top.sv */
`default_nettype none
module stc_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, reset_i, psel, penable, pwrite, aux, fire, which, e;
  logic pready, pslverr, irq_o, ext, auxp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] pdir, pread, uses, pins, dirs;
  logic [15:0] count_o;
  logic [3:0] mode;
  stc_pkg::stc_ccp_type c_lo, c_hi;
  int err_count, tests_run, cyc, g, t;
  stc_timer stc_timer_inst (
    .clk_i, .reset_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq_o, .aux_oscillator_enable_i(aux),
    .external_count_input_i(ext), .aux_osc_in_pin_i(auxp),
    .port_c_pins_i(pins), .port_c_direction_i(dirs), .ccp_low_i(c_lo),
    .ccp_high_i(c_hi), .port_dir_o(pdir), .port_read_o(pread),
    .ccp_uses_this_timer_o(uses), .count_o
  );
  stc_far_model stc_far_model_inst (
    .clk_i, .reset_i, .fire_i(fire), .which_i(which), .mode_i(mode),
    .ccp_low_o(c_lo), .ccp_high_o(c_hi), .ext_o(ext), .aux_o(auxp)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // tg raises a match in the setup cycle so it lands on the access edge
  task bus(input logic w, input logic [7:0] a, d, input logic tg);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    fire <= tg;
    @(posedge clk_i);
    penable <= 1'b1;
    fire <= 1'b0;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      err_count++;
      end_of_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task wr(input logic [7:0] a, d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr
  task rd(input string n, input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 8'h00, 1'b0);
    check(n, r, x);
  endtask : rd
  task wait_chg;
    logic [15:0] c;
    c = count_o;
    g = 0;
    do
    begin
      @(posedge clk_i);
      g++;
    end
    while (count_o === c && g < 400);
    if (g >= 400)
    begin
      err_count++;
      end_of_test;
    end
  endtask : wait_chg
  task trig(input logic w);
    which <= w;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : trig
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, aux, fire, which} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode = 4'hB;
    pins = 2'h3;
    dirs = 2'h1;
    reset_i = 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd("ctrl", 8'h08, 32'h0);
    rd("low", 8'h00, 32'h0);
    rd("high", 8'h04, 32'h0);
    rd("status", 8'h0C, 32'h0);
    rd("mask", 8'h10, 32'h0);
    bus(1'b0, 8'h14, 8'h00, 1'b0);
    check("unmapped", {r[30:0], e}, 32'h1);
    wr(8'h04, 8'h12);
    wr(8'h00, 8'h34);
    repeat (20) @(posedge clk_i);
    rd("narrow_lo", 8'h00, 32'h34);
    rd("narrow_hi", 8'h04, 32'h12);
    wr(8'h08, 8'h80);
    wr(8'h04, 8'hAB);
    check("buffered", count_o, 32'h1234);
    rd("buffer", 8'h04, 32'hAB);
    wr(8'h00, 8'hCD);
    check("wide_load", count_o, 32'hABCD);
    wr(8'h04, 8'h77);
    rd("wide_lo", 8'h00, 32'hCD);
    rd("wide_hi", 8'h04, 32'hAB);
    for (int p = 0; p < 4; p++)
    begin
      wr(8'h08, 8'(p << 4) | 8'h01);
      wait_chg;
      wait_chg;
      check("period", g, 4 << p);
    end
    wait_chg;
    t = cyc;
    wr(8'h04, count_o[15:8]);
    wait_chg;
    check("psc_kept", cyc - t, 32);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'h01);
    wr(8'h04, 8'hFF);
    wr(8'h00, 8'hFE);
    wr(8'h08, 8'h01);
    wait_chg;
    wait_chg;
    check("wrapped", count_o, 32'h0);
    @(posedge clk_i);
    check("irq_on", irq_o, 32'h1);
    rd("flag", 8'h0C, 32'h1);
    wr(8'h10, 8'h00);
    @(posedge clk_i);
    check("irq_mask", irq_o, 32'h0);
    wr(8'h0C, 8'h01);
    rd("flag_clr", 8'h0C, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h08, {1'b0, k[1], 2'b00, k[0], 3'b000});
      repeat (2) @(posedge clk_i);
      check("timebase", uses, {k[1] | k[0], k[1]});
    end
    wr(8'h08, 8'h71);
    for (int m = 0; m < 16; m++)
    begin
      wr(8'h04, 8'h12);
      wr(8'h00, 8'h34);
      mode <= 4'(m);
      trig(m[0]);
      check("trigger", count_o, m == 11 ? 32'h0 : 32'h1234);
    end
    mode <= 4'hB;
    wr(8'h08, 8'h39);
    trig(1'b0);
    check("not_base", count_o, 32'h1234);
    trig(1'b1);
    check("is_base", count_o, 32'h0);
    rd("no_flag", 8'h0C, 32'h0);
    wr(8'h08, 8'h71);
    wr(8'h04, 8'h12);
    bus(1'b1, 8'h00, 8'h56, 1'b1);
    check("write_wins", count_o, 32'h1256);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h03);
    stc_far_model_inst.pulse(5, 1'b0);
    repeat (8) @(posedge clk_i);
    check("ext_count", count_o, 32'h5);
    pins <= 2'h1;
    dirs <= 2'h2;
    repeat (4) @(posedge clk_i);
    check("pins_plain", {pdir, pread}, 32'h9);
    aux <= 1'b1;
    repeat (2) @(posedge clk_i);
    check("aux_pins", {pdir, pread}, 32'hC);
    stc_far_model_inst.pulse(3, 1'b1);
    stc_far_model_inst.pulse(2, 1'b0);
    repeat (8) @(posedge clk_i);
    check("aux_count", count_o, 32'h8);
    end_of_test;
  end
endmodule : stc_timer_tb_top
`default_nettype wire
